/* File: core/scr_pkg.sv */
package scr_pkg;

	// configuration indexes of this slice
	localparam logic [7:0] IDX_ECP_FIFO_THRESHOLD = 8'h0a;
	localparam logic [7:0] IDX_DRIVE_RATE_TABLE_SELECT = 8'h0b;
	localparam logic [7:0] IDX_UART_MODE_CONTROL = 8'h0c;
	localparam logic [7:0] IDX_DEVICE_IDENTIFIER = 8'h0d;
	localparam logic [7:0] IDX_REVISION_IDENTIFIER = 8'h0e;
	localparam logic [7:0] IDX_FACTORY_TEST_BITS = 8'h0f;
	localparam logic [7:0] IDX_CLOCK_GENERATOR_CONTROL = 8'h10;

	// reset values
	localparam logic [7:0] RST_ECP_FIFO_THRESHOLD = 8'h00;
	localparam logic [7:0] RST_DRIVE_RATE_TABLE_SELECT = 8'h00;
	localparam logic [7:0] RST_UART_MODE_CONTROL = 8'h00;
	localparam logic [7:0] RST_FACTORY_TEST_BITS = 8'h00;
	localparam logic [7:0] RST_CLOCK_GENERATOR_CONTROL = 8'h00;

	// writable bit masks; other bits read zero
	localparam logic [7:0] MASK_ECP_FIFO_THRESHOLD = 8'h0f;
	localparam logic [7:0] MASK_CLOCK_GENERATOR_CONTROL = 8'hf8;

	// uart mode control field positions
	localparam int UMC_RX_INVERT = 0;
	localparam int UMC_TX_INVERT = 1;
	localparam int UMC_HALF_DUPLEX = 2;
	localparam int UMC_ENC_LSB = 3;
	localparam int UMC_UART1_FAST = 6;
	localparam int UMC_UART2_FAST = 7;

	// clock generator control field positions
	localparam int CGC_LOOP_GAIN = 3;
	localparam int CGC_LOOP_HALT = 4;
	localparam int CGC_UART_CLOCK_GATE = 5;
	localparam int CGC_REF_SELECT = 6;
	localparam int CGC_IR_TEST = 7;

	// second uart encodings
	localparam logic [2:0] ENC_STANDARD = 3'h0;
	localparam logic [2:0] ENC_PULSE_IR = 3'h1;
	localparam logic [2:0] ENC_ASK_IR = 3'h2;

	// identity codes; values arbitrary
	localparam logic [7:0] DEF_DEVICE_ID = 8'h5a;
	localparam logic [7:0] DEF_REVISION_ID = 8'h01;

	typedef struct packed {
		logic [7:0] ecp_fifo_threshold;
		logic [7:0] drive_rate_table_select;
		logic [7:0] uart_mode_control;
		logic [7:0] factory_test_bits;
		logic [7:0] clock_generator_control;
		logic [7:0] rdata;
		logic rvalid;
	} scr_state_t;

	typedef struct packed {
		logic [1:0] drive3;
		logic [1:0] drive2;
		logic [1:0] drive1;
		logic [1:0] floppy_drive_zero;
	} scr_rate_sel_t;

endpackage

/* File: core/scr_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module scr_regs
	import scr_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = DEF_DEVICE_ID,
	parameter logic [7:0] REVISION_ID = DEF_REVISION_ID
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// configuration access from the index/data front end
	input wire logic CFG_MODE_IN,
	input wire logic [7:0] CFG_INDEX_IN,
	input wire logic CFG_WR_IN,
	input wire logic CFG_RD_IN,
	input wire logic [7:0] CFG_WDATA_IN,
	output logic [7:0] CFG_RDATA_OUT,
	output logic CFG_RVALID_OUT,
	// serial data paths of the second uart
	input wire logic UART2_RX_PIN_IN,
	input wire logic UART2_TX_CORE_IN,
	input wire logic UART_RX_DATA_IN,
	output logic UART2_RX_CORE_OUT,
	output logic UART2_TX_PIN_OUT,
	output logic SERIAL_OUTPUT_PIN_OUT,
	// controls to the function units
	output logic [3:0] PARALLEL_FIFO_LEVEL_TRIGGER_OUT,
	output scr_rate_sel_t RATE_TABLE_SEL_OUT,
	output logic UART2_HALF_DUPLEX_OUT,
	output logic [2:0] UART2_ENCODING_OUT,
	output logic UART1_HIGH_SPEED_OUT,
	output logic UART2_HIGH_SPEED_OUT,
	output logic [7:0] TEST_BITS_OUT,
	output logic MULTIPLIER_LOOP_GAIN_OUT,
	output logic MULTIPLIER_LOOP_HALT_OUT,
	output logic UART_CLOCK_GATE_OUT,
	output logic REF_CLOCK_SELECT_OUT
);

	scr_state_t state;
	scr_state_t next_state;
	logic [1:0] rx_sync;
	logic rx_pin;
	logic [1:0] txc_sync;
	logic [1:0] rxd_sync;
	logic rx_core;
	logic tx_pin;
	logic ser_out;

	// read mux, used by the data port; reserved bits and unused indexes come back zero
	function automatic logic [7:0] read_reg(input scr_state_t s, input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			IDX_ECP_FIFO_THRESHOLD: v = s.ecp_fifo_threshold & MASK_ECP_FIFO_THRESHOLD;
			IDX_DRIVE_RATE_TABLE_SELECT: v = s.drive_rate_table_select;
			IDX_UART_MODE_CONTROL: v = s.uart_mode_control;
			IDX_DEVICE_IDENTIFIER: v = DEVICE_ID;
			IDX_REVISION_IDENTIFIER: v = REVISION_ID;
			IDX_FACTORY_TEST_BITS: v = s.factory_test_bits;
			IDX_CLOCK_GENERATOR_CONTROL: v = s.clock_generator_control & MASK_CLOCK_GENERATOR_CONTROL;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb begin
		next_state = state;
		next_state.rvalid = 1'b0;
		if (CFG_MODE_IN && CFG_WR_IN) begin
			case (CFG_INDEX_IN)
				IDX_ECP_FIFO_THRESHOLD:
					next_state.ecp_fifo_threshold = CFG_WDATA_IN & MASK_ECP_FIFO_THRESHOLD;
				IDX_DRIVE_RATE_TABLE_SELECT:
					next_state.drive_rate_table_select = CFG_WDATA_IN;
				IDX_UART_MODE_CONTROL:
					next_state.uart_mode_control = CFG_WDATA_IN;
				// test bits stored as written; software keeps them zero
				IDX_FACTORY_TEST_BITS:
					next_state.factory_test_bits = CFG_WDATA_IN;
				IDX_CLOCK_GENERATOR_CONTROL:
					next_state.clock_generator_control =
						CFG_WDATA_IN & MASK_CLOCK_GENERATOR_CONTROL;
				default: next_state = next_state;
			endcase
		end
		if (CFG_MODE_IN && CFG_RD_IN) begin
			next_state.rdata = read_reg(state, CFG_INDEX_IN);
			next_state.rvalid = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state.ecp_fifo_threshold <= RST_ECP_FIFO_THRESHOLD;
			state.drive_rate_table_select <= RST_DRIVE_RATE_TABLE_SELECT;
			state.uart_mode_control <= RST_UART_MODE_CONTROL;
			state.factory_test_bits <= RST_FACTORY_TEST_BITS;
			state.clock_generator_control <= RST_CLOCK_GENERATOR_CONTROL;
			state.rdata <= 8'h00;
			state.rvalid <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// pin inputs cross two flops before any use
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			rx_sync <= 2'h0;
			txc_sync <= 2'h0;
			rxd_sync <= 2'h0;
		end else begin
			rx_sync <= {rx_sync[0], UART2_RX_PIN_IN};
			txc_sync <= {txc_sync[0], UART2_TX_CORE_IN};
			rxd_sync <= {rxd_sync[0], UART_RX_DATA_IN};
		end
	end
	assign rx_pin = rx_sync[1];

	always_comb begin
		rx_core = rx_pin ^ state.uart_mode_control[UMC_RX_INVERT];
		tx_pin = txc_sync[1] ^ state.uart_mode_control[UMC_TX_INVERT];
		// ir test: mirror both rx and tx traffic (idle high, so and-merge)
		if (state.clock_generator_control[CGC_IR_TEST]) begin
			ser_out = rxd_sync[1] & txc_sync[1];
		end else begin
			ser_out = tx_pin;
		end
	end

	// every output registered; serial paths add one cycle of latency
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			UART2_RX_CORE_OUT <= 1'b1;
			UART2_TX_PIN_OUT <= 1'b1;
			SERIAL_OUTPUT_PIN_OUT <= 1'b1;
			CFG_RDATA_OUT <= 8'h00;
			CFG_RVALID_OUT <= 1'b0;
			PARALLEL_FIFO_LEVEL_TRIGGER_OUT <= 4'h0;
			RATE_TABLE_SEL_OUT <= '0;
			UART2_HALF_DUPLEX_OUT <= 1'b0;
			UART2_ENCODING_OUT <= ENC_STANDARD;
			UART1_HIGH_SPEED_OUT <= 1'b0;
			UART2_HIGH_SPEED_OUT <= 1'b0;
			TEST_BITS_OUT <= 8'h00;
			MULTIPLIER_LOOP_GAIN_OUT <= 1'b0;
			MULTIPLIER_LOOP_HALT_OUT <= 1'b0;
			UART_CLOCK_GATE_OUT <= 1'b0;
			REF_CLOCK_SELECT_OUT <= 1'b0;
		end else begin
			UART2_RX_CORE_OUT <= rx_core;
			UART2_TX_PIN_OUT <= tx_pin;
			SERIAL_OUTPUT_PIN_OUT <= ser_out;
			CFG_RDATA_OUT <= next_state.rdata;
			CFG_RVALID_OUT <= next_state.rvalid;
			PARALLEL_FIFO_LEVEL_TRIGGER_OUT <= next_state.ecp_fifo_threshold[3:0];
			RATE_TABLE_SEL_OUT <= scr_rate_sel_t'(next_state.drive_rate_table_select);
			UART2_HALF_DUPLEX_OUT <= next_state.uart_mode_control[UMC_HALF_DUPLEX];
			// reserved codes pass through; the uart treats them as it sees fit
			UART2_ENCODING_OUT <= next_state.uart_mode_control[UMC_ENC_LSB +: 3];
			UART1_HIGH_SPEED_OUT <= next_state.uart_mode_control[UMC_UART1_FAST];
			UART2_HIGH_SPEED_OUT <= next_state.uart_mode_control[UMC_UART2_FAST];
			TEST_BITS_OUT <= next_state.factory_test_bits;
			MULTIPLIER_LOOP_GAIN_OUT <= next_state.clock_generator_control[CGC_LOOP_GAIN];
			MULTIPLIER_LOOP_HALT_OUT <= next_state.clock_generator_control[CGC_LOOP_HALT];
			// one bit both gates the 24 MHz feed and holds the dividers reset
			UART_CLOCK_GATE_OUT <= next_state.clock_generator_control[CGC_UART_CLOCK_GATE];
			REF_CLOCK_SELECT_OUT <= next_state.clock_generator_control[CGC_REF_SELECT];
		end
	end

endmodule

`default_nettype wire

/* File: sim/scr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module scr_host (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in,
	output logic mode_out,
	output logic [7:0] index_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] wdata_out
);
	initial {mode_out, index_out, wr_out, rd_out, wdata_out} = '0;
	// idle index and data scrambled so stale values never pass
	task automatic acc(input logic m, input logic [7:0] i, input logic w, input logic [7:0] d,
		output logic [7:0] q, output logic v);
		@(negedge clk_in);
		{mode_out, index_out, wr_out, rd_out, wdata_out} = {m, i, w, !w, d};
		@(negedge clk_in);
		{q, v} = {rdata_in, rvalid_in};
		{index_out, wr_out, rd_out, wdata_out} = {~i, 2'b00, ~d};
	endtask
endmodule
`default_nettype wire

/* File: sim/scr_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module scr_regs_chk
	import scr_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = DEF_DEVICE_ID,
	parameter logic [7:0] REVISION_ID = DEF_REVISION_ID
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic CFG_MODE_IN,
	input wire logic [7:0] CFG_INDEX_IN,
	input wire logic CFG_WR_IN,
	input wire logic CFG_RD_IN,
	input wire logic [7:0] CFG_WDATA_IN,
	input wire logic [7:0] CFG_RDATA_OUT,
	input wire logic CFG_RVALID_OUT,
	input wire logic [3:0] PARALLEL_FIFO_LEVEL_TRIGGER_OUT,
	input wire logic UART_CLOCK_GATE_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence s_rd(idx);
		CFG_MODE_IN && CFG_RD_IN && CFG_INDEX_IN == idx;
	endsequence
	sequence s_wr(idx);
		CFG_MODE_IN && CFG_WR_IN && CFG_INDEX_IN == idx;
	endsequence
	a_read_valid: assert property (CFG_MODE_IN && CFG_RD_IN |=> CFG_RVALID_OUT)
		else $error("read gave no valid");
	a_read_quiet: assert property (!(CFG_MODE_IN && CFG_RD_IN) |=>
		!CFG_RVALID_OUT && $stable(CFG_RDATA_OUT)) else $error("read data moved unasked");
	a_device_id: assert property (s_rd(IDX_DEVICE_IDENTIFIER) |=> CFG_RDATA_OUT == DEVICE_ID)
		else $error("device code wrong");
	a_revision_id: assert property (s_rd(IDX_REVISION_IDENTIFIER) |=>
		CFG_RDATA_OUT == REVISION_ID) else $error("revision code wrong");
	a_thr_write: assert property (s_wr(IDX_ECP_FIFO_THRESHOLD) |=>
		PARALLEL_FIFO_LEVEL_TRIGGER_OUT == $past(CFG_WDATA_IN[3:0])) else $error("threshold lost");
	a_gate_write: assert property (s_wr(IDX_CLOCK_GENERATOR_CONTROL) |=>
		UART_CLOCK_GATE_OUT == $past(CFG_WDATA_IN[5])) else $error("clock gate lost");
	a_thr_upper: assert property (s_rd(IDX_ECP_FIFO_THRESHOLD) |=> CFG_RDATA_OUT[7:4] == 4'h0)
		else $error("threshold upper bits set");
	a_clk_reserved: assert property (s_rd(IDX_CLOCK_GENERATOR_CONTROL) |=>
		CFG_RDATA_OUT[2:0] == 3'h0) else $error("clock reserved bits set");
endmodule
bind scr_regs scr_regs_chk #(.DEVICE_ID(DEVICE_ID), .REVISION_ID(REVISION_ID)) i_scr_regs_chk (.*);
`default_nettype wire

/* File: sim/test_scr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_scr_regs
	import scr_pkg::*;
;
	logic CLK_IN = 0, RST_IN = 1, CFG_MODE_IN, CFG_WR_IN, CFG_RD_IN, CFG_RVALID_OUT, v, md;
	logic UART2_RX_PIN_IN = 1, UART2_TX_CORE_IN = 1, UART_RX_DATA_IN = 1;
	logic [7:0] CFG_INDEX_IN, CFG_WDATA_IN, CFG_RDATA_OUT, TEST_BITS_OUT, q, i, d;
	logic UART2_RX_CORE_OUT, UART2_TX_PIN_OUT, SERIAL_OUTPUT_PIN_OUT, UART2_HALF_DUPLEX_OUT;
	logic UART1_HIGH_SPEED_OUT, UART2_HIGH_SPEED_OUT, MULTIPLIER_LOOP_GAIN_OUT;
	logic MULTIPLIER_LOOP_HALT_OUT, UART_CLOCK_GATE_OUT, REF_CLOCK_SELECT_OUT;
	logic [3:0] PARALLEL_FIFO_LEVEL_TRIGGER_OUT;
	logic [2:0] UART2_ENCODING_OUT;
	scr_rate_sel_t RATE_TABLE_SEL_OUT;
	logic [7:0] m [10:16];
	int fail_count = 0, num_checks = 0, seed = 84, cyc = 0;
	scr_regs i_scr_regs (.*);
	scr_host i_scr_host (.clk_in(CLK_IN), .rdata_in(CFG_RDATA_OUT), .rvalid_in(CFG_RVALID_OUT),
		.mode_out(CFG_MODE_IN), .index_out(CFG_INDEX_IN), .wr_out(CFG_WR_IN), .rd_out(CFG_RD_IN),
		.wdata_out(CFG_WDATA_IN));
	always #50 CLK_IN = ~CLK_IN;
	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc == 9000) begin
			fail_count++;
			complete_run();
		end
	end
	function automatic logic [7:0] expv(input logic [7:0] a);
		case (a)
			8'h0a: return m[10] & 8'h0f;
			8'h0b, 8'h0c, 8'h0f: return m[a];
			8'h0d: return DEF_DEVICE_ID;
			8'h0e: return DEF_REVISION_ID;
			8'h10: return m[16] & 8'hf8;
			default: return 8'h00;
		endcase
	endfunction
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w);
		i_scr_host.acc(md, i, w, d, q, v);
		if (md && w && i inside {[8'h0a:8'h0c], 8'h0f, 8'h10}) m[i] = d;
		if (!w) cmp({7'h0, v}, {7'h0, md});
		if (!w && md) cmp(q, expv(i));
	endtask
	task automatic ctl;
		{UART2_RX_PIN_IN, UART2_TX_CORE_IN, UART_RX_DATA_IN} = 3'($random(seed));
		repeat (4) @(negedge CLK_IN);
		cmp(RATE_TABLE_SEL_OUT, m[11]);
		cmp({PARALLEL_FIFO_LEVEL_TRIGGER_OUT, 4'h0}, {m[10][3:0], 4'h0});
		cmp(TEST_BITS_OUT, m[15]);
		cmp({UART2_HIGH_SPEED_OUT, UART1_HIGH_SPEED_OUT, UART2_ENCODING_OUT, UART2_HALF_DUPLEX_OUT,
			UART2_RX_CORE_OUT, UART2_TX_PIN_OUT}, {m[12][7:2], UART2_RX_PIN_IN ^ m[12][0],
			UART2_TX_CORE_IN ^ m[12][1]});
		cmp({REF_CLOCK_SELECT_OUT, UART_CLOCK_GATE_OUT, MULTIPLIER_LOOP_HALT_OUT,
			MULTIPLIER_LOOP_GAIN_OUT, SERIAL_OUTPUT_PIN_OUT, 3'h0}, {m[16][6:3], m[16][7] ?
			UART_RX_DATA_IN & UART2_TX_CORE_IN : UART2_TX_CORE_IN ^ m[12][1], 3'h0});
	endtask
	task automatic complete_run;
		$display("checks %0d failures %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// second pass follows a mid-run reset
	initial begin
		repeat (16) @(negedge CLK_IN);
		RST_IN = 0;
		repeat (2) begin
			foreach (m[k]) m[k] = 8'h00;
			md = 1;
			for (int k = 9; k <= 17; k++) begin
				i = 8'(k);
				acc(0);
			end
			ctl();
			repeat (70) begin
				i = 8'h09 + 8'($unsigned($random(seed)) % 9);
				d = (i == 8'h0f) ? 8'h00 : 8'($random(seed));
				md = ($random(seed) & 3) != 0;
				acc(1);
				acc(0);
				md = 1;
				acc(0);
				ctl();
			end
			RST_IN = 1;
			repeat (3) @(negedge CLK_IN);
			RST_IN = 0;
		end
		complete_run();
	end
endmodule
`default_nettype wire
